// file: core/eeprom_target.sv
/*
  EEPROM target end: decodes start/stop, addressing, page writes, reads, timed program.
  Assumes SCL is sampled by the link clock (LCLK), a free-running sampler; bus pins arrive asynchronously.
*/
// Functional notes
// - master sends two address bytes, high first
// - acknowledge each address and write data byte
// - stop ends write and starts programming
// - ignore everything while programming runs
// - page writes load up to 32 bytes
// - master may send 31 more bytes, acked
// - increment only the five low address bits
// - in-page address wraps within the page
// - polling acked only after programming completes
// - read uses direction bit one
// - counter holds last address plus one
// - read counter wraps across whole array
// - current read outputs byte at counter
// - random read uses dummy write then restart
// - sequential read continues while master acks
// - match type and select pins or standby
// - write-protect input guards the whole array
// - program time counted from valid stop
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_link_regs.svh"
module eeprom_target (
  input  wire logic LCLK,
  input  wire logic RESET_N,
  eeprom_link_if.dev LINK,
  input  wire logic CHIP_SELECT_PIN_2,
  input  wire logic CHIP_SELECT_PIN_1,
  input  wire logic CHIP_SELECT_PIN_0,
  input  wire logic WRITE_PROTECT,
  output logic      BUSY
);
  parameter int PROG_CYCLES = `PROG_CYCLES;

  typedef enum logic [2:0] {
    IDLE, DEV_ADDR, ADDR_HI, ADDR_LO, WDATA, RDATA, RACK, PROG
  } state_t;

  typedef struct packed {
    logic [2:0]            scl_s;
    logic [2:0]            sda_s;
    state_t                st;
    logic [3:0]            bitn;
    logic [7:0]            shreg;
    logic                  ack_phase;
    logic                  sda_oe;
    logic [`ADDR_W-1:0]    addr;
    logic [`ADDR_W-1:0]    page_addr;
    logic [2:0]            wp_s;
    logic [`ADDR_W-1:0]    hi;
    logic                  wrote;
    logic [22:0]           cnt;
    logic                  busy;
  } st_t;

  st_t s_reg, s_next;
  logic [7:0] mem [0:`MEM_BYTES-1];
  logic [7:0] page_buf [0:31];
  logic [7:0] rd_byte;
  logic       pbuf_we;
  logic       mem_we;

  // =========================================================================
  // helpers
  function automatic logic [`ADDR_W-1:0] page_inc(input logic [`ADDR_W-1:0] a);
    page_inc = {a[`ADDR_W-1:`PAGE_LSB_W], a[`PAGE_LSB_W-1:0] + 5'h01};
  endfunction : page_inc

  // =========================================================================
  // protocol engine
  logic scl_rise, scl_fall, scl_hi, sda_v, start_c, stop_c;
  always_comb begin
    s_next   = s_reg;
    pbuf_we  = 1'b0;
    mem_we   = 1'b0;
    s_next.scl_s = {s_reg.scl_s[1:0], LINK.scl};
    s_next.sda_s = {s_reg.sda_s[1:0], LINK.sda};
    s_next.wp_s  = {s_reg.wp_s[1:0], WRITE_PROTECT};
    scl_hi   = s_reg.scl_s[2] & s_reg.scl_s[1];
    sda_v    = s_reg.sda_s[1];
    scl_rise = s_reg.scl_s[1] & ~s_reg.scl_s[2];
    scl_fall = ~s_reg.scl_s[1] & s_reg.scl_s[2];
    start_c  = scl_hi & s_reg.sda_s[2] & ~sda_v;
    stop_c   = scl_hi & ~s_reg.sda_s[2] & sda_v;
    if (s_reg.st == PROG) begin
      s_next.sda_oe = 1'b0;
      if (s_reg.cnt == 23'h000000) begin
        s_next.st   = IDLE;
        s_next.busy = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt - 23'h000001;
      end
    end else if (start_c) begin
      s_next.st = DEV_ADDR;
      s_next.bitn = 4'h0;
      s_next.ack_phase = 1'b0;
      s_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_next.sda_oe = 1'b0;
      // page_addr already points one past the last loaded byte
      if (s_reg.wrote) s_next.addr = s_reg.page_addr;
      if (s_reg.wrote && !s_reg.wp_s[2]) begin
        s_next.st   = PROG;
        s_next.cnt  = 23'(PROG_CYCLES);
        s_next.busy = 1'b1;
        mem_we      = 1'b1;
      end else begin
        s_next.st = IDLE;
      end
      s_next.wrote = 1'b0;
    end else if (s_reg.st != IDLE && scl_rise && !s_reg.ack_phase) begin
      s_next.shreg = {s_reg.shreg[6:0], sda_v};
      s_next.bitn  = s_reg.bitn + 4'h1;
    end else if (s_reg.st != IDLE && scl_fall) begin
      if (s_reg.ack_phase) begin
        s_next.ack_phase = 1'b0;
        s_next.bitn = 4'h0;
        s_next.sda_oe = (s_reg.st == RDATA) ? ~rd_byte[7] : 1'b0;
        s_next.shreg  = rd_byte;
      end else if (s_reg.st == RDATA && s_reg.bitn != 4'h8) begin
        // shreg moves left on each rise, so its msb is always the next bit
        s_next.sda_oe = ~s_reg.shreg[7];
      end else if (s_reg.bitn == 4'h8) begin
        s_next.ack_phase = 1'b1;
        s_next.sda_oe = 1'b1;
        unique case (s_reg.st)
          DEV_ADDR: begin
            if (s_reg.shreg[7:4] != `TYPE_ID || s_reg.shreg[3:1] !=
                {CHIP_SELECT_PIN_2, CHIP_SELECT_PIN_1, CHIP_SELECT_PIN_0}) begin
              s_next.st = IDLE;
              s_next.sda_oe = 1'b0;
            end else if (s_reg.shreg[0]) begin
              s_next.st = RDATA;
            end else begin
              s_next.st = ADDR_HI;
            end
          end
          ADDR_HI: begin
            s_next.hi = {s_reg.shreg[3:0], 8'h00};
            s_next.st = ADDR_LO;
          end
          ADDR_LO: begin
            s_next.addr = s_reg.hi | {4'h0, s_reg.shreg};
            s_next.page_addr = s_reg.hi | {4'h0, s_reg.shreg};
            s_next.st = WDATA;
          end
          WDATA: begin
            pbuf_we = 1'b1;
            s_next.wrote = 1'b1;
            s_next.page_addr = page_inc(s_reg.page_addr);
          end
          RDATA: begin
            s_next.sda_oe = 1'b0;
            s_next.st = RACK;
          end
          default: s_next.st = IDLE;
        endcase
      end
    end else if (s_reg.st == RACK && scl_rise) begin
      // counter moves past the byte just sent, acked or not
      s_next.addr = s_reg.addr + 12'h001;
      if (sda_v) begin
        s_next.st = IDLE;
      end else begin
        s_next.st = RDATA;
        s_next.bitn = 4'h0;
        s_next.ack_phase = 1'b1;
      end
    end
  end

  // read byte: first one is at the counter, then incremented
  assign rd_byte = mem[(s_reg.st == RACK) ? s_reg.addr + 12'h001 : s_reg.addr];

  // =========================================================================
  // storage; page buffer drains to array on stop
  always_ff @(posedge LCLK) begin
    if (pbuf_we) page_buf[s_reg.page_addr[`PAGE_LSB_W-1:0]] <= s_reg.shreg;
  end

  // only page slots loaded this sequence are programmed
  logic [31:0] loaded_reg;
  always_ff @(posedge LCLK or negedge RESET_N) begin
    if (!RESET_N) loaded_reg <= 32'h00000000;
    else if (s_reg.st == ADDR_LO) loaded_reg <= 32'h00000000;
    else if (pbuf_we) loaded_reg[s_reg.page_addr[`PAGE_LSB_W-1:0]] <= 1'b1;
  end

  always_ff @(posedge LCLK) begin
    if (mem_we) begin
      for (int i = 0; i < 32; i++) begin
        if (loaded_reg[i])
          mem[{s_reg.page_addr[`ADDR_W-1:`PAGE_LSB_W], 5'(i)}] <= page_buf[i];
      end
    end
  end

  always_ff @(posedge LCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_reg <= '0;
      s_reg.scl_s <= 3'h7;
      s_reg.sda_s <= 3'h7;
      s_reg.st <= IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.sda_dev_oe = s_reg.sda_oe;
  assign BUSY = s_reg.busy;
endmodule : eeprom_target
`default_nettype wire

// file: common/eeprom_link_regs.svh
/*
  Constants for the two-wire EEPROM link: geometry, address fields, timing counts.
  Assumes it is included by bare name from design files.
*/
`ifndef EEPROM_LINK_REGS_SVH
`define EEPROM_LINK_REGS_SVH

`define MEM_BYTES          4096
`define ADDR_W             12
`define PAGE_LSB_W         5
// type identifier; arbitrary neutral value
`define TYPE_ID            4'h5
`define PROG_TIME_US       5000
`define LINK_CLK_NS        30
`define PROG_CYCLES        ((`PROG_TIME_US * 1000 + `LINK_CLK_NS - 1) / `LINK_CLK_NS)
`define HOST_CLK_NS        100
`define SCL_HALF_CYCLES    8'h05

`endif

// file: common/eeprom_link_pkg.sv
/*
  Types shared by the host end and the bench of the two-wire EEPROM link.
  Assumes nothing beyond the constants header.
*/
package eeprom_link_pkg;
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RANDOM
  } op_t;
endpackage : eeprom_link_pkg

// file: common/eeprom_link_if.sv
/*
  Two-wire open-drain link: clock from host, shared data wire.
  Assumes a pull-up: the wire is low while any end enables its driver.
*/
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;
  assign sda = !(sda_host_oe || sda_dev_oe);
  modport host (output scl, output sda_host_oe, input sda);
  modport dev  (input scl, output sda_dev_oe, input sda);
endinterface : eeprom_link_if
`default_nettype wire

// file: core/eeprom_master.sv
/*
  Host end: drives SCL by divider from CLK, runs write/read command sequences.
  Assumes a simple request port; one command at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_link_regs.svh"
module eeprom_master (
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  eeprom_link_if.host               LINK,
  input  wire logic                 REQ,
  input  wire eeprom_link_pkg::op_t OP,
  input  wire logic [2:0]           SEL,
  input  wire logic [11:0]          ADDR,
  input  wire logic [7:0]           WDATA,
  input  wire logic [5:0]           LEN,
  output logic                      DONE,
  output logic                      NACK,
  output logic                      RVALID,
  output logic [7:0]                RDATA
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_END} hst_t;
  typedef struct packed {
    hst_t        st;
    logic [7:0]  div;
    logic [1:0]  ph;
    logic        scl;
    logic        oe;
    logic [3:0]  bitn;
    logic [8:0]  sh;
    logic [2:0]  seg;
    logic        rd;
    logic [5:0]  left;
    eeprom_link_pkg::op_t op;
    logic [2:0]  sel;
    logic [11:0] addr;
    logic [7:0]  wd;
    logic [2:0]  sda_s;
    logic        done;
    logic        nack;
    logic        rvalid;
    logic [7:0]  rdata;
  } m_t;
  m_t m_reg, m_next;
  logic tick;

  function automatic logic [8:0] byte_of(input m_t m, input logic [2:0] seg);
    unique case (seg)
      3'h0: byte_of = {`TYPE_ID, m.sel, m.op == eeprom_link_pkg::OP_READ_CUR, 1'b1};
      3'h1: byte_of = {4'h0, m.addr[11:8], 1'b1};
      3'h2: byte_of = {m.addr[7:0], 1'b1};
      3'h3: byte_of = {m.wd, 1'b1};
      default: byte_of = {`TYPE_ID, m.sel, 1'b1, 1'b1};
    endcase
  endfunction : byte_of

  // =========================================================================
  // four quarter-phase bit engine; scl from divider
  always_comb begin
    m_next = m_reg;
    m_next.sda_s = {m_reg.sda_s[1:0], LINK.sda};
    m_next.done = 1'b0;
    m_next.rvalid = 1'b0;
    tick = (m_reg.div == `SCL_HALF_CYCLES);
    m_next.div = tick ? 8'h00 : m_reg.div + 8'h01;
    if (m_reg.st == H_IDLE) begin
      m_next.div = 8'h00;
      m_next.ph = 2'h0;
      if (REQ) begin
        m_next.op = OP; m_next.sel = SEL; m_next.addr = ADDR;
        m_next.wd = WDATA; m_next.left = LEN;
        m_next.seg = 3'h0;
        m_next.nack = 1'b0;
        m_next.st = H_START;
      end
    end else if (tick) begin
      m_next.ph = m_reg.ph + 2'h1;
      unique case (m_reg.st)
        H_START: begin
          unique case (m_reg.ph)
            2'h0: begin m_next.oe = 1'b0; m_next.scl = 1'b1; end
            2'h1: m_next.oe = 1'b1;
            2'h2: m_next.scl = 1'b0;
            default: begin
              m_next.st = H_BIT; m_next.bitn = 4'h0;
              m_next.sh = byte_of(m_reg, m_reg.seg);
              // every address byte is driven by the host; data phase sets rd
              m_next.rd = 1'b0;
            end
          endcase
        end
        H_BIT: begin
          unique case (m_reg.ph)
            2'h0: m_next.oe = m_reg.rd && m_reg.bitn != 4'h8 ? 1'b0 : ~m_reg.sh[8];
            2'h1: m_next.scl = 1'b1;
            2'h2: m_next.sh = {m_reg.sh[7:0], m_reg.sda_s[2]};
            default: begin
              m_next.scl = 1'b0;
              m_next.bitn = m_reg.bitn + 4'h1;
              if (m_reg.bitn == 4'h8) begin
                m_next.bitn = 4'h0;
                if (m_reg.seg == 3'h5) begin
                  m_next.st = m_reg.sh[0] ? H_STOP : H_BIT;
                end else if (m_reg.sh[0]) begin
                  m_next.nack = 1'b1; // polling: no ack while busy
                  m_next.st = H_STOP;
                end else if (m_reg.seg == 3'h4 ||
                             m_reg.seg == 3'h0 && m_reg.op == eeprom_link_pkg::OP_READ_CUR) begin
                  m_next.seg = 3'h5; // read data bytes
                  m_next.rd = 1'b1;
                end else if (m_reg.seg == 3'h0) begin
                  m_next.seg = 3'h1; m_next.sh = byte_of(m_reg, 3'h1);
                end else if (m_reg.seg == 3'h1) begin
                  m_next.seg = 3'h2; m_next.sh = byte_of(m_reg, 3'h2);
                end else if (m_reg.seg == 3'h2 &&
                             m_reg.op == eeprom_link_pkg::OP_READ_RANDOM) begin
                  m_next.seg = 3'h4; m_next.st = H_START;
                end else if (m_reg.seg == 3'h2) begin
                  m_next.seg = 3'h3; m_next.sh = byte_of(m_reg, 3'h3);
                end else if (m_reg.seg == 3'h3 && m_reg.left > 6'h01) begin
                  m_next.left = m_reg.left - 6'h01;
                  m_next.sh = byte_of(m_reg, 3'h3);
                end else begin
                  m_next.st = H_STOP;
                end
              end
            end
          endcase
          if (m_reg.seg == 3'h5 && m_reg.ph == 2'h3 && m_reg.bitn == 4'h7) begin
            m_next.rdata = m_reg.sh[7:0];
            m_next.rvalid = 1'b1;
            m_next.left = m_reg.left - 6'h01;
            // ack bit of this byte; left still counts it, so 1 means last byte
            m_next.sh = {(m_reg.left <= 6'h01), 8'h00};
          end
        end
        H_STOP: begin
          unique case (m_reg.ph)
            2'h0: m_next.oe = 1'b1;
            2'h1: m_next.scl = 1'b1;
            2'h2: m_next.oe = 1'b0;
            default: m_next.st = H_END;
          endcase
        end
        default: begin
          m_next.done = 1'b1;
          m_next.st = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      m_reg <= '0;
      m_reg.scl <= 1'b1;
      m_reg.sda_s <= 3'h7;
      m_reg.st <= H_IDLE;
    end else begin
      m_reg <= m_next;
    end
  end

  assign LINK.scl = m_reg.scl;
  assign LINK.sda_host_oe = m_reg.oe;
  assign DONE = m_reg.done;
  assign NACK = m_reg.nack;
  assign RVALID = m_reg.rvalid;
  assign RDATA = m_reg.rdata;
endmodule : eeprom_master
`default_nettype wire

// file: verif/eeprom_link_assertions.sv
/*
  Checker for the two-wire link between the host end and the target end.
  Assumes link-clock sampling; bench top ties the link signals by name.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_assertions #(
  parameter int PROG_CYCLES = 2000
) (
  input wire logic LCLK,
  input wire logic RESET_N,
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda,
  input wire logic BUSY
);
  // ==========================================
  // monitor state
  typedef struct packed {
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  since_stop;
    logic [19:0] busy_cnt;
  } mon_t;
  mon_t mon_reg;
  mon_t mon_next;
  always_comb begin
    mon_next = mon_reg;
    mon_next.scl_d = scl;
    mon_next.sda_d = sda;
    // saturating, so an old stop never looks recent
    if (scl && mon_reg.scl_d && sda && !mon_reg.sda_d) begin
      mon_next.since_stop = 4'h0;
    end else if (mon_reg.since_stop != 4'hf) begin
      mon_next.since_stop = mon_reg.since_stop + 4'h1;
    end
    mon_next.busy_cnt = BUSY ? mon_reg.busy_cnt + 20'h1 : 20'h0;
  end
  always_ff @(posedge LCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mon_reg <= {1'b1, 1'b1, 4'hf, 20'h0};
    end else begin
      mon_reg <= mon_next;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge LCLK); endclocking
  default disable iff (!RESET_N);
  busy_no_drive_a: assert property (BUSY |-> !sda_dev_oe)
    else $error("target drives data while programming");
  ack_drive_a: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("target pulls data while clock high");
  ack_release_a: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("target releases data while clock high");
  dev_hold_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("target data moves during clock high");
  prog_start_a: assert property ($rose(BUSY) |-> mon_reg.since_stop < 4'hc)
    else $error("programming began without a stop");
  prog_len_a: assert property ($fell(BUSY) |-> mon_reg.busy_cnt >= PROG_CYCLES - 1
    && mon_reg.busy_cnt <= PROG_CYCLES + 2) else $error("programming time wrong");
  prog_hold_a: assert property ($rose(BUSY) |=> BUSY [*8])
    else $error("programming ended at once");
  scl_pulse_a: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  cover property ($rose(BUSY));
  cover property ($fell(BUSY));
  cover property ($rose(sda_dev_oe) && !sda_host_oe);
endmodule : eeprom_link_assertions
`default_nettype wire

// file: verif/serial_eeprom_rw_protocol_tb.sv
/*
  Bench: host end and target end joined by the link, command table, checker beside.
  Assumes design files, package and constants header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_rw_protocol_tb;
  // ==========================================
  // signals
  localparam int PROG = 2000;
  localparam eeprom_link_pkg::op_t WR = eeprom_link_pkg::OP_WRITE;
  localparam eeprom_link_pkg::op_t RC = eeprom_link_pkg::OP_READ_CUR;
  localparam eeprom_link_pkg::op_t RR = eeprom_link_pkg::OP_READ_RANDOM;
  typedef struct {
    eeprom_link_pkg::op_t op;
    logic [2:0]  sel;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [5:0]  len;
    logic        wp;
    logic        exp_nack;
  } row_t;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic reset_n;
  logic req;
  logic done;
  logic nack;
  logic rvalid;
  logic busy;
  logic wp;
  eeprom_link_pkg::op_t op;
  logic [2:0]  sel;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [5:0]  len;
  logic [7:0]  mem_m [4096];
  logic [11:0] ctr_m;
  logic [7:0]  got [$];
  row_t        rows [10];
  int          err_count = 0;
  int          num_checks = 0;
  eeprom_link_if eeprom_link_if_inst ();
  eeprom_master eeprom_master_inst (.CLK(clk), .RESET_N(reset_n), .LINK(eeprom_link_if_inst),
    .REQ(req), .OP(op), .SEL(sel), .ADDR(addr), .WDATA(wdata), .LEN(len), .DONE(done),
    .NACK(nack), .RVALID(rvalid), .RDATA(rdata));
  // select pins tied at 5 for the whole run
  eeprom_target #(.PROG_CYCLES(PROG)) eeprom_target_inst (.LCLK(lclk), .RESET_N(reset_n),
    .LINK(eeprom_link_if_inst), .CHIP_SELECT_PIN_2(1'b1), .CHIP_SELECT_PIN_1(1'b0),
    .CHIP_SELECT_PIN_0(1'b1), .WRITE_PROTECT(wp), .BUSY(busy));
  eeprom_link_assertions #(.PROG_CYCLES(PROG)) eeprom_link_assertions_inst (.LCLK(lclk),
    .RESET_N(reset_n), .scl(eeprom_link_if_inst.scl),
    .sda_host_oe(eeprom_link_if_inst.sda_host_oe),
    .sda_dev_oe(eeprom_link_if_inst.sda_dev_oe), .sda(eeprom_link_if_inst.sda), .BUSY(busy));
  // ==========================================
  // clocks and tasks
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // hold low skips the wait for programming, so a poll can follow at once
  task automatic run(input row_t r, input logic hold);
    int n;
    logic [11:0] start;
    logic up;
    @(negedge clk);
    op = r.op;
    {sel, addr, wdata, len, wp} = {r.sel, r.addr, r.wdata, r.len, r.wp};
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    got.delete();
    n = 0;
    do begin
      @(negedge clk);
      if (rvalid === 1'b1) got.push_back(rdata);
      n++;
    end while (done !== 1'b1 && n < 20000);
    if (done !== 1'b1) begin
      err_count++;
      $display("Error at %0t: command never completed", $time);
    end
    check({7'h00, nack}, {7'h00, r.exp_nack});
    if (r.exp_nack) return;
    if (r.op == WR) begin
      for (int i = 0; i < r.len; i++) begin
        if (!r.wp) mem_m[{r.addr[11:5], 5'(r.addr[4:0] + i)}] = r.wdata;
      end
      ctr_m = {r.addr[11:5], 5'(r.addr[4:0] + r.len)};
      if (hold) begin
        for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge clk);
        up = (busy === 1'b1);
        check({7'h00, up}, {7'h00, !r.wp});
        for (n = 0; n < 2000 && busy === 1'b1; n++) @(negedge clk);
        check({7'h00, busy}, 8'h00);
      end
    end else begin
      start = (r.op == RR) ? r.addr : ctr_m;
      check(8'(got.size()), {2'h0, r.len});
      for (int i = 0; i < got.size(); i++) begin
        check(got[i], mem_m[12'(start + i)]);
      end
      ctr_m = 12'(start + r.len);
    end
  endtask : run
  // ==========================================
  // sequence
  initial begin
    rows = '{
      '{WR, 3'h5, 12'h020, 8'h11, 6'h20, 1'b0, 1'b0},
      '{WR, 3'h5, 12'h03e, 8'h22, 6'h04, 1'b0, 1'b0},
      '{RC, 3'h5, 12'h000, 8'h00, 6'h02, 1'b0, 1'b0},
      '{RR, 3'h5, 12'h020, 8'h00, 6'h03, 1'b0, 1'b0},
      '{WR, 3'h5, 12'hfff, 8'h33, 6'h01, 1'b0, 1'b0},
      '{WR, 3'h5, 12'h000, 8'h44, 6'h01, 1'b0, 1'b0},
      '{RR, 3'h5, 12'hfff, 8'h00, 6'h02, 1'b0, 1'b0},
      '{WR, 3'h5, 12'h000, 8'h55, 6'h01, 1'b1, 1'b0},
      '{RR, 3'h5, 12'h000, 8'h00, 6'h01, 1'b0, 1'b0},
      '{WR, 3'h2, 12'h000, 8'h77, 6'h01, 1'b0, 1'b1}};
    {req, sel, addr, wdata, len, wp, reset_n} = {1'b0, 3'h5, 12'h000, 8'h00, 6'h01, 1'b0, 1'b0};
    op = WR;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check({4'h0, done, nack, rvalid, busy}, 8'h00);
    check({6'h00, eeprom_link_if_inst.scl, eeprom_link_if_inst.sda}, 8'h03);
    foreach (rows[k]) run(rows[k], 1'b1);
    // poll while the target is still programming
    run('{WR, 3'h5, 12'h100, 8'h66, 6'h01, 1'b0, 1'b0}, 1'b0);
    run('{RR, 3'h5, 12'h100, 8'h00, 6'h01, 1'b0, 1'b1}, 1'b1);
    for (int n = 0; n < 2000 && busy === 1'b1; n++) @(negedge clk);
    run('{RR, 3'h5, 12'h100, 8'h00, 6'h01, 1'b0, 1'b0}, 1'b1);
    test_done();
  end
  initial begin
    #6000000;
    err_count++;
    test_done();
  end
endmodule : serial_eeprom_rw_protocol_tb
`default_nettype wire
